/* rtl/tcc_pkg.sv */
// Constants and carrier types of the 16-bit capture/compare timer
package tcc_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_MODE = 6'h00;
   localparam logic [5:0] OFF_CCCTL = 6'h04;
   localparam logic [5:0] OFF_PRESC = 6'h08;
   localparam logic [5:0] OFF_OUTCTL = 6'h0C;
   localparam logic [5:0] OFF_COUNT = 6'h10;
   localparam logic [5:0] OFF_CCA = 6'h14;
   localparam logic [5:0] OFF_CCB = 6'h18;
   localparam logic [5:0] OFF_STAT = 6'h1C;
   localparam logic [5:0] OFF_MASK = 6'h20;

   // ==========================================================
   // Field positions
   localparam int OVF_BIT = 0;
   localparam int RUN_LO = 2;
   localparam int CC_MODE_BIT = 0;
   localparam int CC_TRIG_BIT = 1;
   localparam int CLKSEL_LO = 0;
   localparam int ESA_LO = 4;
   localparam int ESB_LO = 6;
   localparam int OUT_EN_BIT = 0;
   localparam int OUT_PPG_BIT = 1;

   // ==========================================================
   // Encodings and reset values
   localparam logic [1:0] RUN_STOP = 2'h0;
   localparam logic [1:0] RUN_FREE = 2'h1;
   localparam logic [1:0] RUN_CLR_EDGE = 2'h2;
   localparam logic [1:0] RUN_CLR_MATCH = 2'h3;
   localparam logic [1:0] ES_FALL = 2'h0;
   localparam logic [1:0] ES_RISE = 2'h1;
   localparam logic [1:0] ES_BOTH = 2'h3;
   localparam logic [1:0] CK_DIV1 = 2'h0;
   localparam logic [1:0] CK_DIVA = 2'h1;
   localparam logic [1:0] CK_DIVB = 2'h2;
   localparam logic [1:0] CK_EXT = 2'h3;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CC_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic match_b;
      logic capture;
      logic overflow;
      logic match_a;
   } tcc_evt_t;

   localparam int EVT_W = 4;

   typedef struct packed {
      logic [1:0] run_mode;
      logic cc_trig_sel;
      logic cc_mode;
      logic [1:0] edge_sel_b;
      logic [1:0] edge_sel_a;
      logic [1:0] clk_sel;
      logic out_ppg;
      logic out_en;
   } tcc_cfg_t;

endpackage : tcc_pkg

/* rtl/tcc_timer.sv */
// 16-bit up-counter with capture/compare, pulse output, AXI4-Lite slave
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps

module tcc_timer #(
   parameter int DIV_A = 4,
   parameter int DIV_B = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_in_a,
   input wire logic timer_in_b,
   output logic timer_out,
   output logic timer_out_oe,
   output logic match_a_irq,
   output logic irq
);

   localparam int PSC_W = $clog2(DIV_B);

   // ==========================================================
   // Helpers
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic rise,
                                     input logic fall);
      logic hit;
      hit = 1'b0;
      case (sel)
         tcc_pkg::ES_FALL: hit = fall;
         tcc_pkg::ES_RISE: hit = rise;
         tcc_pkg::ES_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : edge_hit

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = data[i*8 +: 8];
      end
      return res;
   endfunction : merge

   // ==========================================================
   // State
   tcc_pkg::tcc_cfg_t cfg;
   tcc_pkg::tcc_evt_t status;
   tcc_pkg::tcc_evt_t mask;
   tcc_pkg::tcc_evt_t evt;
   logic [15:0] up_counter;
   logic [15:0] capcomp_reg_a;
   logic [15:0] capcomp_reg_b;
   logic [PSC_W-1:0] psc;
   logic ti_a_q;
   logic ti_b_q;
   logic aw_got;
   logic w_got;
   logic [5:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // ==========================================================
   // Bus decode
   wire wr_go = aw_got & w_got & ~s_axi_bvalid;
   wire rd_go = s_axi_arvalid & s_axi_arready;
   wire wr_mode = wr_go & (aw_addr == tcc_pkg::OFF_MODE);
   wire wr_ccctl = wr_go & (aw_addr == tcc_pkg::OFF_CCCTL);
   wire wr_presc = wr_go & (aw_addr == tcc_pkg::OFF_PRESC);
   wire wr_outctl = wr_go & (aw_addr == tcc_pkg::OFF_OUTCTL);
   wire wr_cca = wr_go & (aw_addr == tcc_pkg::OFF_CCA);
   wire wr_ccb = wr_go & (aw_addr == tcc_pkg::OFF_CCB);
   wire wr_stat = wr_go & (aw_addr == tcc_pkg::OFF_STAT);
   wire wr_mask = wr_go & (aw_addr == tcc_pkg::OFF_MASK);
   wire wr_hit = wr_mode | wr_ccctl | wr_presc | wr_outctl | wr_cca
      | wr_ccb | wr_stat | wr_mask | (aw_addr == tcc_pkg::OFF_COUNT);
   // Freezing the tick on a counter read avoids a torn value
   wire rd_hold = rd_go & (s_axi_araddr == tcc_pkg::OFF_COUNT);
   wire [31:0] w_old = 32'h00000000;
   wire [31:0] w_val = merge(w_old, w_data, w_strb);
   wire [31:0] cca_wr = merge({16'h0000, capcomp_reg_a}, w_data, w_strb);
   wire [31:0] ccb_wr = merge({16'h0000, capcomp_reg_b}, w_data, w_strb);

   logic [31:0] rd_val;
   logic rd_ok;
   always_comb
   begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         tcc_pkg::OFF_MODE:
         begin
            rd_val[tcc_pkg::RUN_LO +: 2] = cfg.run_mode;
            rd_val[tcc_pkg::OVF_BIT] = status.overflow;
         end
         tcc_pkg::OFF_CCCTL:
         begin
            rd_val[tcc_pkg::CC_MODE_BIT] = cfg.cc_mode;
            rd_val[tcc_pkg::CC_TRIG_BIT] = cfg.cc_trig_sel;
         end
         tcc_pkg::OFF_PRESC:
         begin
            rd_val[tcc_pkg::CLKSEL_LO +: 2] = cfg.clk_sel;
            rd_val[tcc_pkg::ESA_LO +: 2] = cfg.edge_sel_a;
            rd_val[tcc_pkg::ESB_LO +: 2] = cfg.edge_sel_b;
         end
         tcc_pkg::OFF_OUTCTL:
         begin
            rd_val[tcc_pkg::OUT_EN_BIT] = cfg.out_en;
            rd_val[tcc_pkg::OUT_PPG_BIT] = cfg.out_ppg;
         end
         tcc_pkg::OFF_COUNT: rd_val[15:0] = up_counter;
         tcc_pkg::OFF_CCA: rd_val[15:0] = capcomp_reg_a;
         tcc_pkg::OFF_CCB: rd_val[15:0] = capcomp_reg_b;
         tcc_pkg::OFF_STAT: rd_val[tcc_pkg::EVT_W-1:0] = status;
         tcc_pkg::OFF_MASK: rd_val[tcc_pkg::EVT_W-1:0] = mask;
         default: rd_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // Count clock and input edges
   wire en_a = (psc & PSC_W'(DIV_A - 1)) == PSC_W'(DIV_A - 1);
   wire en_b = psc == PSC_W'(DIV_B - 1);
   wire rise_a = timer_in_a & ~ti_a_q;
   wire fall_a = ~timer_in_a & ti_a_q;
   wire rise_b = timer_in_b & ~ti_b_q;
   wire fall_b = ~timer_in_b & ti_b_q;
   // Input edges are seen only if each level spans the sampling
   wire valid_a = edge_hit(cfg.edge_sel_a, rise_a, fall_a);
   // Capture from input A uses the opposite edge; code 11 disables it
   wire cap_src_a = (cfg.edge_sel_a != tcc_pkg::ES_BOTH)
      & edge_hit(cfg.edge_sel_a, fall_a, rise_a);
   wire cap_src_b = edge_hit(cfg.edge_sel_b, rise_b, fall_b);
   wire running = cfg.run_mode != tcc_pkg::RUN_STOP;

   logic base_tick;
   always_comb
   begin
      case (cfg.clk_sel)
         tcc_pkg::CK_DIV1: base_tick = 1'b1;
         tcc_pkg::CK_DIVA: base_tick = en_a;
         tcc_pkg::CK_DIVB: base_tick = en_b;
         tcc_pkg::CK_EXT: base_tick = valid_a;
         default: base_tick = 1'b0;
      endcase
   end

   wire tick = running & base_tick & ~rd_hold;
   wire at_cca = up_counter == capcomp_reg_a;
   wire at_ccb = up_counter == capcomp_reg_b;
   wire cyc_end = tick & at_cca;
   wire edge_clr = running & valid_a
      & (cfg.run_mode == tcc_pkg::RUN_CLR_EDGE);
   wire match_clr = cyc_end
      & (cfg.run_mode == tcc_pkg::RUN_CLR_MATCH);
   // Pulse-width capture resolves to one clock of edge detect
   wire cap_go = running & cfg.cc_mode
      & (cfg.cc_trig_sel ? cap_src_a : cap_src_b);

   logic [15:0] next_counter;
   always_comb
   begin
      if (!running)
         next_counter = tcc_pkg::CNT_ZERO;
      else if (edge_clr || match_clr)
         next_counter = tcc_pkg::CNT_ZERO;
      else if (tick)
         next_counter = 16'(up_counter + 16'h0001);
      else
         next_counter = up_counter;
   end

   always_comb
   begin
      evt.match_a = cyc_end & ~cfg.cc_mode;
      evt.overflow = tick & (up_counter == tcc_pkg::CNT_MAX);
      evt.capture = cap_go;
      evt.match_b = tick & at_ccb;
   end

   // Output goes low the clock after out_en clears; the pin is shared with input A
   logic next_out;
   always_comb
   begin
      next_out = timer_out;
      if (!cfg.out_en)
         next_out = 1'b0;
      else if (cfg.out_ppg)
      begin
         if (cyc_end)
            next_out = 1'b1;
         else if (evt.match_b)
            next_out = 1'b0;
      end
      else if (cyc_end)
         next_out = ~timer_out;
   end

   // ==========================================================
   // Timer state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         up_counter <= tcc_pkg::CNT_ZERO;
         psc <= '0;
         ti_a_q <= 1'b0;
         ti_b_q <= 1'b0;
         timer_out <= 1'b0;
         match_a_irq <= 1'b0;
      end
      else
      begin
         up_counter <= next_counter;
         psc <= PSC_W'(psc + 1'b1);
         ti_a_q <= timer_in_a;
         ti_b_q <= timer_in_b;
         timer_out <= next_out;
         match_a_irq <= evt.match_a;
      end
   end

   // ==========================================================
   // Software registers; hardware capture beats a software write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg <= '0;
         capcomp_reg_a <= tcc_pkg::CC_RESET;
         capcomp_reg_b <= tcc_pkg::CC_RESET;
         mask <= '0;
         status <= '0;
      end
      else
      begin
         if (wr_mode)
            cfg.run_mode <= w_val[tcc_pkg::RUN_LO +: 2];
         if (wr_ccctl)
         begin
            cfg.cc_mode <= w_val[tcc_pkg::CC_MODE_BIT];
            cfg.cc_trig_sel <= w_val[tcc_pkg::CC_TRIG_BIT];
         end
         if (wr_presc)
         begin
            cfg.clk_sel <= w_val[tcc_pkg::CLKSEL_LO +: 2];
            cfg.edge_sel_a <= w_val[tcc_pkg::ESA_LO +: 2];
            cfg.edge_sel_b <= w_val[tcc_pkg::ESB_LO +: 2];
         end
         if (wr_outctl)
         begin
            cfg.out_en <= w_val[tcc_pkg::OUT_EN_BIT];
            cfg.out_ppg <= w_val[tcc_pkg::OUT_PPG_BIT];
         end
         if (cap_go)
            capcomp_reg_a <= up_counter;
         else if (wr_cca)
            capcomp_reg_a <= cca_wr[15:0];
         if (wr_ccb)
            capcomp_reg_b <= ccb_wr[15:0];
         if (wr_mask)
            mask <= w_val[tcc_pkg::EVT_W-1:0];
         // Set wins over a same-cycle write-one clear
         status <= (status & ~(wr_stat ? w_val[tcc_pkg::EVT_W-1:0]
            : 4'h0)) | evt;
      end
   end

   assign irq = |(status & mask);
   assign timer_out_oe = cfg.out_en;

   // ==========================================================
   // AXI4-Lite handshakes; one write and one read at a time
   assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
   assign s_axi_wready = ~w_got & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 6'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tcc_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= tcc_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? tcc_pkg::RESP_OKAY
               : tcc_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? tcc_pkg::RESP_OKAY
               : tcc_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule : tcc_timer

/* tb/tb.sv */
// Self-checking bench for the capture/compare timer
`timescale 1ns/10ps
// ==========================================================
// Bench top
module tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, timer_in_a;
   logic timer_in_b, timer_out, timer_out_oe, match_a_irq, irq, ob;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, v, r1;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs, cd;
   int mismatches, total_checks, cyc, hs, c1, g;

   tcc_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .timer_in_a, .timer_in_b, .timer_out,
      .timer_out_oe, .match_a_irq, .irq);
   tcc_pulse_src src (.aclk, .timer_in_a, .timer_in_b);

   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;

   // ==========================================================
   // Tasks
   task automatic conclude;
      if (mismatches == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Every wait is bounded, so a hung handshake ends the run
   task automatic step(inout int n);
      @(posedge aclk);
      n++;
      if (n > 400)
      begin
         chk("timeout", 32'h1, 32'h0);
         conclude;
      end
   endtask : step
   task automatic wr(input logic [5:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      int n;
      logic pa, pw;
      n = 0;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (pa || pw)
      begin
         step(n);
         if (pa && s_axi_awready)
         begin
            pa = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (pw && s_axi_wready)
         begin
            pw = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      // Late bready leaves the response waiting one cycle
      step(n);
      step(n);
      s_axi_bready <= 1'b1;
      do step(n); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do step(n); while (!s_axi_arready);
      hs = cyc;
      s_axi_arvalid <= 1'b0;
      step(n);
      s_axi_rready <= 1'b1;
      do step(n); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic w(input logic [5:0] a, input logic [31:0] d);
      wr(a, d, rs);
   endtask : w
   task automatic rc(input string nm, input logic [5:0] a,
                     input logic [31:0] e);
      rd(a, v, rs);
      chk(nm, v, e);
   endtask : rc
   // Cycles between events: 0 match pulse, 1 output rise, 2 any toggle
   task automatic gap(input int k, output int gg);
      int n, t0;
      logic p, hit;
      n = 0;
      t0 = -1;
      gg = -1;
      p = timer_out;
      while (gg < 0)
      begin
         step(n);
         hit = k == 0 ? match_a_irq === 1'b1 : k == 1 ?
            (timer_out === 1'b1 && p === 1'b0) : timer_out !== p;
         if (hit && t0 >= 0)
            gg = cyc - t0;
         if (hit)
            t0 = cyc;
         p = timer_out;
      end
   endtask : gap

   // ==========================================================
   // Sequence
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 14'h0;
      {s_axi_awprot, s_axi_arprot} = 6'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {mismatches, total_checks, cyc} = 96'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rc("count", tcc_pkg::OFF_COUNT, 32'h0); // cleared
      rc("cca", tcc_pkg::OFF_CCA, 32'h0);
      wr(tcc_pkg::OFF_COUNT, 32'hFFFF, rs);
      chk("ro resp", rs, tcc_pkg::RESP_OKAY); // read-only
      rc("ro count", tcc_pkg::OFF_COUNT, 32'h0); // unchanged
      rd(6'h24, v, rs);
      chk("bad rresp", rs, tcc_pkg::RESP_SLVERR);
      chk("bad rdata", v, 32'h0);
      wr(6'h24, 32'h1, rs);
      chk("bad bresp", rs, tcc_pkg::RESP_SLVERR);
      w(tcc_pkg::OFF_MODE, 32'h4);
      rd(tcc_pkg::OFF_COUNT, r1, rs);
      c1 = hs;
      rd(tcc_pkg::OFF_COUNT, v, rs);
      chk("count step", v, r1 + hs - c1 - 1); // held
      w(tcc_pkg::OFF_MODE, 32'h0);
      rc("stop", tcc_pkg::OFF_COUNT, 32'h0); // cleared
      for (int n = 1; n < 6; n += 4)
      begin
         w(tcc_pkg::OFF_CCA, n);
         w(tcc_pkg::OFF_OUTCTL, 32'h1);
         w(tcc_pkg::OFF_MASK, 32'h1);
         w(tcc_pkg::OFF_MODE, 32'hC);
         gap(0, g);
         chk("interval", g, n + 1); // period
         gap(2, g);
         chk("half wave", g, n + 1); // toggle
         chk("irq set", irq, 32'h1); // raised
         w(tcc_pkg::OFF_MASK, 32'h0);
         chk("irq masked", irq, 32'h0);
         w(tcc_pkg::OFF_MODE, 32'h0);
         w(tcc_pkg::OFF_STAT, 32'h1);
         w(tcc_pkg::OFF_MASK, 32'h1);
         chk("irq clear", irq, 32'h0);
      end
      w(tcc_pkg::OFF_PRESC, 32'h1);
      w(tcc_pkg::OFF_MODE, 32'hC);
      gap(0, g);
      chk("div a", g, 32'h18); // six ticks of aclk/4
      w(tcc_pkg::OFF_PRESC, 32'h2);
      gap(0, g);
      chk("div b", g, 32'h60); // six ticks of aclk/16
      w(tcc_pkg::OFF_MODE, 32'h0);
      w(tcc_pkg::OFF_PRESC, 32'h0);
      w(tcc_pkg::OFF_CCA, 32'h9);
      w(tcc_pkg::OFF_CCB, 32'h3);
      w(tcc_pkg::OFF_OUTCTL, 32'h3);
      w(tcc_pkg::OFF_MODE, 32'hC);
      gap(1, g);
      chk("pulse period", g, 32'hA); // cca plus one
      g = 0;
      c1 = 0;
      while (timer_out === 1'b1)
      begin
         g++;
         step(c1);
      end
      chk("pulse width", g, 32'h4); // ccb plus one
      w(tcc_pkg::OFF_MODE, 32'h0);
      w(tcc_pkg::OFF_OUTCTL, 32'h0);
      chk("oe off", timer_out_oe, 32'h0); // pin free for input
      w(tcc_pkg::OFF_PRESC, 32'h10);
      w(tcc_pkg::OFF_MODE, 32'h8);
      src.drive(1'b0, 1'b0, 40);
      src.drive(1'b0, 1'b1, 16);
      rd(tcc_pkg::OFF_COUNT, v, rs);
      chk("edge clear", v < 32'h1E, 32'h1); // rise clears
      src.drive(1'b0, 1'b0, 16);
      rd(tcc_pkg::OFF_COUNT, v, rs);
      chk("no fall clear", v >= 32'h1E, 32'h1); // fall ignored
      w(tcc_pkg::OFF_MODE, 32'h0);
      w(tcc_pkg::OFF_PRESC, 32'h13);
      w(tcc_pkg::OFF_MODE, 32'h4);
      repeat (3)
      begin
         src.drive(1'b0, 1'b1, 16);
         src.drive(1'b0, 1'b0, 16);
      end
      rc("events", tcc_pkg::OFF_COUNT, 32'h3); // one per rising edge
      for (int i = 0; i < 7; i++)
      begin
         // Codes 00, 01, 11 only, never 10
         cd = i % 3 == 2 ? 2'h3 : 2'(i % 3);
         ob = i > 2 && i < 6;
         w(tcc_pkg::OFF_CCCTL, i == 6 ? 32'h2 : ob ? 32'h1 : 32'h3);
         w(tcc_pkg::OFF_PRESC, ob ? {24'h0, cd, 6'h0} : {26'h0, cd, 4'h0});
         w(tcc_pkg::OFF_CCA, 32'h0);
         src.drive(ob, 1'b1, 16);
         rd(tcc_pkg::OFF_CCA, r1, rs);
         chk("cap rise", r1 != 0, (7'h31 >> i) & 7'h01);
         src.drive(ob, 1'b0, 16);
         rd(tcc_pkg::OFF_CCA, v, rs);
         chk("cap fall", v != r1, (7'h2A >> i) & 7'h01);
      end
      w(tcc_pkg::OFF_MODE, 32'h0);
      w(tcc_pkg::OFF_STAT, 32'hF);
      rc("stat w1c", tcc_pkg::OFF_STAT, 32'h0); // flags cleared
      w(tcc_pkg::OFF_MODE, 32'h4);
      repeat (65540) @(posedge aclk);
      rd(tcc_pkg::OFF_STAT, v, rs);
      chk("ovf stat", v[1], 32'h1); // wrap seen
      rc("ovf mode", tcc_pkg::OFF_MODE, 32'h5); // free run
      chk("irq match", irq, 32'h1); // compare at zero
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rc("rst count", tcc_pkg::OFF_COUNT, 32'h0); // cleared
      rc("rst mode", tcc_pkg::OFF_MODE, 32'h0); // stopped
      conclude;
   end
endmodule : tb

/* tb/tcc_pulse_src.sv */
// Pulse source model for the two timer inputs
`timescale 1ns/10ps
// ==========================================================
// Source
module tcc_pulse_src (
   input wire logic aclk,
   output logic timer_in_a,
   output logic timer_in_b
);
   initial
   begin
      timer_in_a = 1'b0;
      timer_in_b = 1'b0;
   end

   // Levels last 16 clocks or more, enough to count and measure
   task automatic drive(input logic on_b, input logic lvl, input int hold);
      int h;
      h = hold < 16 ? 16 : hold;
      @(posedge aclk);
      if (on_b)
         timer_in_b <= lvl;
      else
         timer_in_a <= lvl;
      repeat (h) @(posedge aclk);
   endtask : drive
endmodule : tcc_pulse_src

/* tb/tcc_timer_monitor.sv */
// Bus and output checker for the capture/compare timer
`timescale 1ns/10ps
// ==========================================================
// Checker
module tcc_timer_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_out,
   input wire logic timer_out_oe,
   input wire logic match_a_irq,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking

   property p_reset_quiet;
      !aresetn |=> !timer_out && !timer_out_oe && !irq && !match_a_irq;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active after reset");
   property p_oe_gate;
      disable iff (!aresetn) !timer_out_oe |-> !timer_out;
   endproperty
   a_oe_gate: assert property (p_oe_gate)
      else $error("output high while not enabled");
   property p_match_pulse;
      disable iff (!aresetn) match_a_irq |=> !match_a_irq;
   endproperty
   a_match_pulse: assert property (p_match_pulse)
      else $error("match pulse longer than one cycle");
   property p_wr_answer;
      disable iff (!aresetn) s_axi_awvalid && s_axi_awready && s_axi_wvalid
         && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response late");
   property p_rd_answer;
      disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read response late");
   property p_rd_hold;
      disable iff (!aresetn) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
         && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data dropped before taken");
   property p_wr_hold;
      disable iff (!aresetn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
         && $stable(s_axi_bresp);
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("write response dropped before taken");
   property p_unmapped;
      disable iff (!aresetn) s_axi_arvalid && s_axi_arready
         && s_axi_araddr > 6'h20 |=> s_axi_rdata == 32'h0
         && s_axi_rresp == tcc_pkg::RESP_SLVERR;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
endmodule : tcc_timer_monitor

bind tcc_timer tcc_timer_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .timer_out, .timer_out_oe, .match_a_irq, .irq);
